// ==== common/run_ctl_pkg.sv ====
// package: register map, field layout and types for debug run control
package run_ctl_pkg;

  localparam int NUM_CORES = 2;
  localparam int NUM_EVENTS = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int TRACE_DEPTH = 16;
  localparam int TRACE_AW = 4;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'hc;
  // IRQ_MASK sits at 4'hd, right after OFS_IRQ_STAT at 4'hc
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hd;
  localparam logic [ADDR_W-1:0] OFS_TRACE_CFG = 4'he;
  localparam logic [ADDR_W-1:0] OFS_TRACE_STAT = 4'hf;

  // ctrl fields
  localparam int CTRL_RST_MASK_BIT = 0;
  localparam int CTRL_TRACE_INT_BIT = 1;
  localparam int CTRL_TRACE_RT_BIT = 2;
  // cmd fields (write pulses)
  localparam int CMD_BREAK_LSB = 0;
  localparam int CMD_RUN_LSB = 2;
  localparam int CMD_STEP_LSB = 4;
  localparam int CMD_DBG_RST_BIT = 6;
  // trace cfg fields
  localparam int TCFG_FULL_STOP_BIT = 0;
  localparam int TCFG_DELAY_STOP_BIT = 1;
  localparam int TCFG_DELAY_LSB = 8;
  localparam int TCFG_DELAY_W = 8;
  // status-interrupt bit positions
  localparam int IRQB_OVERFLOW = 0;
  localparam int IRQB_DBG_RST = 1;
  localparam int IRQB_BREAK = 2;
  localparam int IRQB_TRACE_STOP = 3;
  localparam int IRQ_W = 4;

  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TCFG_RESET = 32'h0000_0000;
  // ids that survive core reset (sys_rst clears them too): debug access, customer a, data flash
  localparam logic [7:0] ID_KEEP_MASK = 8'h07;

  typedef enum logic [2:0] {
    RUN_EXEC = 3'b001,
    RUN_BREAK = 3'b010,
    RUN_STEP = 3'b100
  } run_state_t;

  typedef struct packed {
    logic valid;
    logic data_cmp;
    logic suppressed;
    logic range_or_type;
    logic data_match;
  } access_evt_t;

  typedef struct packed {
    logic maskable_irq;
    logic fast_maskable_irq;
    logic fast_nonmaskable_irq;
  } irq_set_t;

endpackage

// ==== src/run_ctl.sv ====
// debug run control: reset and interrupt masking, halt, trace capture
// How it works
// - single-step state masks user system and user program resets
// - emulator reset always applies, regardless of mask or run state
// - after emulator reset every core is put into break
// - software reset after resuming from break may be lost
// - single-step masks maskable, fast maskable and fast nonmaskable irqs
// - irqs arriving while masked stay pending until unmasked
// - a break request releases a core from halt mode
// - halt in single step breaks at next instruction, no halt
// - up to four access events reported in one cycle
// - suppressed accesses never hit data-compare events
// - type-point or range tracing ignores data comparison
// - trace overflow sets a sticky loss flag
// - full stop and delayed stop only with internal realtime trace
// - core reset drops id authentications except three kept ids; sys_rst clears all
module run_ctl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [run_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic [run_ctl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [run_ctl_pkg::DATA_W-1:0] rdata,
  output logic irq,
  input wire logic user_rst_req,
  input wire logic [run_ctl_pkg::NUM_CORES-1:0] sw_rst_req,
  output logic core_rst,
  input wire run_ctl_pkg::irq_set_t [run_ctl_pkg::NUM_CORES-1:0] irq_in,
  output run_ctl_pkg::irq_set_t [run_ctl_pkg::NUM_CORES-1:0] irq_out,
  input wire logic [run_ctl_pkg::NUM_CORES-1:0] irq_ack,
  input wire logic [run_ctl_pkg::NUM_CORES-1:0] halt_instr,
  input wire logic [run_ctl_pkg::NUM_CORES-1:0] step_done,
  output logic [run_ctl_pkg::NUM_CORES-1:0] halted,
  output logic [run_ctl_pkg::NUM_CORES-1:0] core_run,
  input wire logic [7:0] id_auth_set,
  output logic [7:0] id_auth,
  input wire run_ctl_pkg::access_evt_t [run_ctl_pkg::NUM_EVENTS-1:0] evt_in,
  input wire logic [run_ctl_pkg::DATA_W-1:0] evt_data,
  output logic [run_ctl_pkg::NUM_EVENTS-1:0] evt_hit,
  input wire logic trace_drain
);
  import run_ctl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  run_state_t [NUM_CORES-1:0] run_reg, run_next;
  logic [NUM_CORES-1:0] halt_reg, halt_next;
  logic [NUM_CORES-1:0] step_halt_reg, step_halt_next;
  irq_set_t [NUM_CORES-1:0] pend_reg, pend_next;
  logic [DATA_W-1:0] ctrl_reg, ctrl_next;
  logic [DATA_W-1:0] tcfg_reg, tcfg_next;
  logic [IRQ_W-1:0] istat_reg, istat_next;
  logic [IRQ_W-1:0] imask_reg, imask_next;
  logic [7:0] auth_reg, auth_next;
  logic [TRACE_AW:0] fill_reg, fill_next;
  logic [TRACE_AW-1:0] wptr_reg, wptr_next;
  logic [TCFG_DELAY_W-1:0] dly_reg, dly_next;
  logic dly_arm_reg, dly_arm_next;
  logic stopped_reg, stopped_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [NUM_EVENTS-1:0] hit_reg, hit_next;
  logic rst_out_reg, rst_out_next;
  logic [DATA_W-1:0] mem_rd;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_step(input run_state_t s);
    return s == RUN_STEP;
  endfunction

  function automatic logic rst_masked(input run_state_t s);
    // break and step always mask; executing never does
    return s != RUN_EXEC;
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic wr_cmd, dbg_rst, any_break, any_masked, evt_any;
  logic rt_internal, trace_wr, overflow, trace_full;
  logic [NUM_CORES-1:0] brk_cmd, run_cmd, step_cmd;

  always_comb begin
    wr_cmd = wr_stb && addr == OFS_CMD;
    brk_cmd = wr_cmd ? wdata[CMD_BREAK_LSB +: NUM_CORES] : '0;
    run_cmd = wr_cmd ? wdata[CMD_RUN_LSB +: NUM_CORES] : '0;
    step_cmd = wr_cmd ? wdata[CMD_STEP_LSB +: NUM_CORES] : '0;
    dbg_rst = wr_cmd && wdata[CMD_DBG_RST_BIT];
    any_break = 1'b0;
    any_masked = 1'b0;
    for (int c = 0; c < NUM_CORES; c++) begin
      if (run_reg[c] == RUN_BREAK) begin
        any_break = 1'b1;
      end
      if (rst_masked(run_reg[c])) begin
        any_masked = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // reset masking
  // ----------------------------------------
  always_comb begin
    rst_out_next = 1'b0;
    if (dbg_rst) begin
      rst_out_next = 1'b1;
    end else if ((user_rst_req || |sw_rst_req) && !any_masked) begin
      // mask option adds nothing beyond break/step masking
      rst_out_next = 1'b1;
    end
  end

  // ----------------------------------------
  // run state, halt and interrupts per core
  // ----------------------------------------
  always_comb begin
    run_next = run_reg;
    halt_next = halt_reg;
    step_halt_next = step_halt_reg;
    pend_next = pend_reg;
    for (int c = 0; c < NUM_CORES; c++) begin
      // capture requests, keep until serviced
      pend_next[c] = pend_reg[c] | irq_in[c];
      if (irq_ack[c] && run_reg[c] == RUN_EXEC) begin
        pend_next[c] = irq_in[c];
      end
      unique case (run_reg[c])
        RUN_EXEC: begin
          if (halt_instr[c]) begin
            halt_next[c] = 1'b1;
          end
          if (brk_cmd[c]) begin
            run_next[c] = RUN_BREAK;
            halt_next[c] = 1'b0;
          end
        end
        RUN_BREAK: begin
          if (run_cmd[c]) begin
            run_next[c] = RUN_EXEC;
          end else if (step_cmd[c]) begin
            run_next[c] = RUN_STEP;
          end
          if (brk_cmd[c]) begin
            halt_next[c] = 1'b0;
          end
        end
        RUN_STEP: begin
          if (halt_instr[c]) begin
            step_halt_next[c] = 1'b1;
          end
          if (step_done[c] || brk_cmd[c] || step_halt_reg[c]) begin
            run_next[c] = RUN_BREAK;
            step_halt_next[c] = 1'b0;
          end
        end
      endcase
    end
    if (rst_out_reg) begin
      for (int c = 0; c < NUM_CORES; c++) begin
        run_next[c] = RUN_BREAK;
      end
      halt_next = '0;
      step_halt_next = '0;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CORES; c++) begin
      // break and step both mask; pending stays held
      irq_out[c] = rst_masked(run_reg[c]) ? '0 : pend_reg[c];
    end
  end

  // ----------------------------------------
  // access events
  // ----------------------------------------
  always_comb begin
    for (int e = 0; e < NUM_EVENTS; e++) begin
      // all four evaluated in parallel
      hit_next[e] = evt_in[e].valid;
      if (evt_in[e].data_cmp && !evt_in[e].range_or_type) begin
        hit_next[e] = evt_in[e].valid && evt_in[e].data_match
                      && !evt_in[e].suppressed;
      end
    end
    // type/range points ignore data compare
    evt_any = |hit_next;
  end

  // ----------------------------------------
  // trace capture
  // ----------------------------------------
  always_comb begin
    rt_internal = ctrl_reg[CTRL_TRACE_INT_BIT] && ctrl_reg[CTRL_TRACE_RT_BIT];
    trace_full = fill_reg == (TRACE_AW+1)'(TRACE_DEPTH);
    trace_wr = evt_any && !stopped_reg && !trace_full;
    overflow = evt_any && !stopped_reg && trace_full;
    wptr_next = trace_wr ? wptr_reg + 1'b1 : wptr_reg;
    fill_next = fill_reg;
    if (trace_wr && !(trace_drain && fill_reg != '0)) begin
      fill_next = fill_reg + 1'b1;
    end else if (!trace_wr && trace_drain && fill_reg != '0) begin
      fill_next = fill_reg - 1'b1;
    end
    stopped_next = stopped_reg;
    dly_arm_next = dly_arm_reg;
    dly_next = dly_reg;
    if (rt_internal) begin
      if (tcfg_reg[TCFG_FULL_STOP_BIT] && fill_next[TRACE_AW]) begin
        stopped_next = 1'b1;
      end
      if (tcfg_reg[TCFG_DELAY_STOP_BIT] && evt_any && !dly_arm_reg) begin
        dly_arm_next = 1'b1;
        dly_next = tcfg_reg[TCFG_DELAY_LSB +: TCFG_DELAY_W];
      end else if (dly_arm_reg && trace_wr) begin
        if (dly_reg == '0) begin
          stopped_next = 1'b1;
        end else begin
          dly_next = dly_reg - 1'b1;
        end
      end
    end
    if (wr_stb && addr == OFS_TRACE_CFG) begin
      stopped_next = 1'b0;
      dly_arm_next = 1'b0;
    end
  end

  trace_mem u_mem (
    .clk(clk),
    .wr_en(trace_wr),
    .wr_addr(wptr_reg),
    .wr_data(evt_data),
    .rd_addr(wptr_reg - fill_reg[TRACE_AW-1:0]),
    .rd_data(mem_rd)
  );

  // ----------------------------------------
  // registers, status and id authentication
  // ----------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    tcfg_next = tcfg_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    if (wr_stb && addr == OFS_CTRL) begin
      ctrl_next = wdata;
    end
    if (wr_stb && addr == OFS_TRACE_CFG) begin
      tcfg_next = wdata;
    end
    if (wr_stb && addr == OFS_IRQ_MASK) begin
      imask_next = wdata[IRQ_W-1:0];
    end
    if (wr_stb && addr == OFS_IRQ_STAT) begin
      istat_next = istat_reg & ~wdata[IRQ_W-1:0];
    end
    // set wins over clear
    if (overflow) begin
      istat_next[IRQB_OVERFLOW] = 1'b1;
    end
    if (dbg_rst) begin
      istat_next[IRQB_DBG_RST] = 1'b1;
    end
    if (|brk_cmd || (any_break && rst_out_reg)) begin
      istat_next[IRQB_BREAK] = 1'b1;
    end
    if (stopped_next && !stopped_reg) begin
      istat_next[IRQB_TRACE_STOP] = 1'b1;
    end
    auth_next = auth_reg | id_auth_set;
    if (rst_out_reg) begin
      auth_next = auth_reg & ID_KEEP_MASK;
    end
  end

  always_comb begin
    rdata_next = '0;
    if (rd_stb) begin
      unique case (addr)
        OFS_CTRL: rdata_next = ctrl_reg;
        OFS_STATUS: begin
          for (int c = 0; c < NUM_CORES; c++) begin
            rdata_next[3*c +: 3] = run_reg[c];
          end
          rdata_next[16 +: NUM_CORES] = halt_reg;
          rdata_next[24 +: 8] = auth_reg;
        end
        OFS_IRQ_STAT: rdata_next[IRQ_W-1:0] = istat_reg;
        OFS_IRQ_MASK: rdata_next[IRQ_W-1:0] = imask_reg;
        OFS_TRACE_CFG: rdata_next = tcfg_reg;
        OFS_TRACE_STAT: begin
          rdata_next[TRACE_AW:0] = fill_reg;
          rdata_next[8] = stopped_reg;
          rdata_next[9] = istat_reg[IRQB_OVERFLOW];
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int c = 0; c < NUM_CORES; c++) begin
        run_reg[c] <= RUN_EXEC;
      end
      halt_reg <= '0;
      step_halt_reg <= '0;
      pend_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      tcfg_reg <= TCFG_RESET;
      istat_reg <= '0;
      imask_reg <= '0;
      auth_reg <= '0;
      fill_reg <= '0;
      wptr_reg <= '0;
      dly_reg <= '0;
      dly_arm_reg <= 1'b0;
      stopped_reg <= 1'b0;
      rdata_reg <= '0;
      hit_reg <= '0;
      rst_out_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      halt_reg <= halt_next;
      step_halt_reg <= step_halt_next;
      pend_reg <= pend_next;
      ctrl_reg <= ctrl_next;
      tcfg_reg <= tcfg_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      auth_reg <= auth_next;
      fill_reg <= fill_next;
      wptr_reg <= wptr_next;
      dly_reg <= dly_next;
      dly_arm_reg <= dly_arm_next;
      stopped_reg <= stopped_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      rst_out_reg <= rst_out_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = rdata_reg;
  assign irq = |(istat_reg & imask_reg);
  assign core_rst = rst_out_reg;
  assign halted = halt_reg;
  assign id_auth = auth_reg;
  assign evt_hit = hit_reg;
  always_comb begin
    for (int c = 0; c < NUM_CORES; c++) begin
      core_run[c] = run_reg[c] == RUN_EXEC;
    end
  end
endmodule

// ==== src/trace_mem.sv ====
// trace memory with registered read data
module trace_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [run_ctl_pkg::TRACE_AW-1:0] wr_addr,
  input wire logic [run_ctl_pkg::DATA_W-1:0] wr_data,
  input wire logic [run_ctl_pkg::TRACE_AW-1:0] rd_addr,
  output logic [run_ctl_pkg::DATA_W-1:0] rd_data
);
  import run_ctl_pkg::*;

  logic [DATA_W-1:0] mem [TRACE_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== tb/dbg_emu.sv ====
// emulator model: register bus master of the run control block
module dbg_emu (
  input wire logic clk,
  output logic [3:0] addr,
  output logic [31:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import run_ctl_pkg::*;
  initial begin
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic dbg_reset();
    wr(OFS_CMD, 32'h0000_0040);
  endtask
endmodule

// ==== tb/debug_run_control_masking_tb_top.sv ====
// testbench for the debug run control block
module debug_run_control_masking_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import run_ctl_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, evt_data, rv, seed;
  logic wr_stb, rd_stb, irq, user_rst_req, core_rst, trace_drain;
  logic [1:0] sw_rst_req, irq_ack, halt_instr, step_done, halted, core_run;
  irq_set_t [1:0] irq_in, irq_out;
  logic [7:0] id_auth_set, id_auth;
  access_evt_t [3:0] evt_in, e;
  logic [3:0] evt_hit, exp_hit, care;
  logic [19:0] corner [3] = '{20'h8_4210, 20'he_f7bd, 20'hd_6b5a};
  int err_count = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  dbg_emu u_emu (.clk, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
  run_ctl u_dut (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .irq, .user_rst_req, .sw_rst_req, .core_rst, .irq_in, .irq_out,
    .irq_ack, .halt_instr, .step_done, .halted, .core_run, .id_auth_set,
    .id_auth, .evt_in, .evt_data, .evt_hit, .trace_drain);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic hit_of(input access_evt_t x);
    return x.valid && (x.range_or_type || !x.data_cmp ||
      (x.data_match && !x.suppressed));
  endfunction
  function automatic logic care_of(input access_evt_t x);
    return !x.suppressed || (x.data_cmp && !x.range_or_type);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic feed(input int n);
    repeat (n) begin
      @(posedge clk);
      evt_in <= 20'h0_0010;
    end
    @(posedge clk);
    evt_in <= '0;
  endtask

  initial begin
    nap(4000);
    err_count++;
    results();
  end

  initial begin
    {user_rst_req, sw_rst_req, irq_ack, halt_instr, step_done} = '0;
    {irq_in, id_auth_set, evt_in, evt_data, trace_drain} = '0;
    seed = 32'd91964;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    nap(1);
    chk(32'(core_run), 32'h0000_0003);
    u_emu.rd(OFS_STATUS, rv);
    chk(rv, 32'h0000_0009);
    u_emu.rd(4'h1, rv);
    chk(rv, 32'h0000_0000);
    @(posedge clk);
    id_auth_set <= 8'hff;
    @(posedge clk);
    id_auth_set <= 8'h00;
    user_rst_req <= 1'b1;
    @(posedge clk);
    user_rst_req <= 1'b0;
    #1;
    chk(32'(core_rst), 32'h0000_0001);
    nap(2);
    chk(32'(id_auth), 32'h0000_0007);
    u_emu.wr(OFS_CTRL, 32'h0000_0002);
    u_emu.wr(OFS_TRACE_CFG, 32'h0000_0001);
    feed(20);
    u_emu.rd(OFS_TRACE_STAT, rv);
    chk(rv & 32'h0000_0300, 32'h0000_0200);
    u_emu.rd(OFS_IRQ_STAT, rv);
    chk(rv & 32'h0000_0001, 32'h0000_0001);
    u_emu.wr(OFS_CTRL, 32'h0000_0006);
    u_emu.wr(OFS_TRACE_CFG, 32'h0000_0001);
    feed(20);
    u_emu.rd(OFS_TRACE_STAT, rv);
    chk(rv & 32'h0000_0100, 32'h0000_0100);
    @(posedge clk);
    trace_drain <= 1'b1;
    repeat (17) @(posedge clk);
    trace_drain <= 1'b0;
    u_emu.wr(OFS_TRACE_CFG, 32'h0000_0302);
    u_emu.rd(OFS_TRACE_STAT, rv);
    chk(rv, 32'h0000_0200);
    feed(8);
    u_emu.rd(OFS_TRACE_STAT, rv);
    chk(rv & 32'h0000_0110, 32'h0000_0100);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      e = (i < 3) ? corner[i] : seed[19:0];
      for (int k = 0; k < 4; k++) begin
        care[k] = care_of(e[k]);
        exp_hit[k] = hit_of(e[k]);
      end
      @(posedge clk);
      evt_in <= e;
      evt_data <= seed;
      nap(1);
      chk(32'(evt_hit & care), 32'(exp_hit & care));
    end
    @(posedge clk);
    evt_in <= '0;
    u_emu.wr(OFS_CMD, 32'h0000_000c);
    @(posedge clk);
    halt_instr <= 2'b01;
    @(posedge clk);
    halt_instr <= 2'b00;
    #1;
    chk(32'(halted), 32'h0000_0001);
    u_emu.wr(OFS_CMD, 32'h0000_0001);
    nap(2);
    chk(32'({halted, core_run}), 32'h0000_0002);
    @(posedge clk);
    sw_rst_req <= 2'b01;
    @(posedge clk);
    sw_rst_req <= 2'b00;
    #1;
    chk(32'(core_rst), 32'h0000_0000);
    u_emu.wr(OFS_CMD, 32'h0000_0002);
    u_emu.wr(OFS_CMD, 32'h0000_0020);
    @(posedge clk);
    irq_in[1] <= 3'b111;
    @(posedge clk);
    irq_in[1] <= 3'b000;
    #1;
    chk(32'(irq_out[1]), 32'h0000_0000);
    u_emu.rd(OFS_STATUS, rv);
    chk(rv, 32'h0700_0022);
    @(posedge clk);
    halt_instr <= 2'b10;
    @(posedge clk);
    halt_instr <= 2'b00;
    nap(2);
    chk(32'(halted), 32'h0000_0000);
    u_emu.rd(OFS_STATUS, rv);
    chk(rv, 32'h0700_0012);
    u_emu.wr(OFS_CMD, 32'h0000_0020);
    u_emu.rd(OFS_STATUS, rv);
    chk(rv, 32'h0700_0022);
    @(posedge clk);
    step_done <= 2'b10;
    @(posedge clk);
    step_done <= 2'b00;
    u_emu.rd(OFS_STATUS, rv);
    chk(rv, 32'h0700_0012);
    u_emu.wr(OFS_CMD, 32'h0000_0008);
    nap(1);
    chk(32'(irq_out[1]), 32'h0000_0007);
    @(posedge clk);
    irq_ack <= 2'b10;
    @(posedge clk);
    irq_ack <= 2'b00;
    #1;
    chk(32'(irq_out[1]), 32'h0000_0000);
    u_emu.wr(OFS_IRQ_MASK, 32'h0000_0002);
    u_emu.dbg_reset();
    #1;
    chk(32'(core_rst), 32'h0000_0001);
    nap(1);
    chk(32'(core_run), 32'h0000_0000);
    nap(2);
    chk(32'(irq), 32'h0000_0001);
    u_emu.wr(OFS_IRQ_STAT, 32'h0000_0002);
    nap(3);
    chk(32'(irq), 32'h0000_0000);
    results();
  end
endmodule

// ==== tb/run_ctl_properties.sv ====
// checker: port properties of the run control block
module run_ctl_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic user_rst_req,
  input wire logic [1:0] sw_rst_req,
  input wire logic core_rst,
  input wire run_ctl_pkg::irq_set_t [1:0] irq_out,
  input wire logic [1:0] core_run,
  input wire logic [1:0] halt_instr,
  input wire logic [1:0] halted,
  input wire run_ctl_pkg::access_evt_t [3:0] evt_in,
  input wire logic [3:0] evt_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  import run_ctl_pkg::*;
  logic cmd_wr;
  logic [1:0] irq_any;
  assign cmd_wr = wr_stb && addr == OFS_CMD;
  assign irq_any = {|irq_out[1], |irq_out[0]};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_dbg_rst_apply: assert property (
    cmd_wr && wdata[6] |=> core_rst) else $error("reset not applied");
  a_dbg_rst_break: assert property (
    cmd_wr && wdata[6] |-> ##2 core_run == 2'b00)
    else $error("cores not in break");
  a_user_rst_pass: assert property (
    user_rst_req && core_run == 2'b11 |=> core_rst)
    else $error("user reset lost");
  a_masked_rst: assert property (
    (user_rst_req || sw_rst_req != 2'b00) && core_run != 2'b11
    && !(cmd_wr && wdata[6]) |=> !core_rst)
    else $error("masked reset passed");
  a_irq_gated: assert property (
    (irq_any & ~core_run) == 2'b00) else $error("irq not masked");
  a_break_unhalt: assert property (
    cmd_wr && wdata[0] |=> !halted[0]) else $error("halt kept");
  a_step_no_halt: assert property (
    !core_run[1] && halt_instr[1] && !halted[1] |=> !halted[1])
    else $error("halt entered in step");
  a_type_hit: assert property (
    evt_in[0].valid && evt_in[0].range_or_type && !evt_in[0].suppressed
    |=> evt_hit[0]) else $error("type event missed");
  a_supp_miss: assert property (
    evt_in[1].data_cmp && evt_in[1].suppressed
    && !evt_in[1].range_or_type |=> !evt_hit[1])
    else $error("suppressed access hit");
  c_dbg_rst: cover property (cmd_wr && wdata[6] ##1 core_rst);
  c_unhalt: cover property (halted[0] ##1 !halted[0]);
  c_four_hits: cover property (evt_hit == 4'hf);
endmodule

bind run_ctl run_ctl_properties u_chk (.clk, .sys_rst, .addr, .wdata,
  .wr_stb, .user_rst_req, .sw_rst_req, .core_rst, .irq_out, .core_run,
  .halt_instr, .halted, .evt_in, .evt_hit);
